// [src/pdp_pkg.sv]
/*
  Shared constants and carrier types for the product-data ROM port:
  configuration offsets, field positions, ROM base address and the
  request/answer structs of the configuration ports and the ROM byte port.
  Assumes a single clock domain for all users.
*/
package pdp_pkg;

  // Dword-aligned configuration offsets
  localparam logic [7:0] PDP_OFF_CAP_ADDR = 8'hE4;
  localparam logic [7:0] PDP_OFF_DATA = 8'hE8;

  // Read-only capability bytes sharing the dword with the address field
  localparam logic [7:0] PDP_CAP_ID = 8'h03;
  localparam logic [7:0] PDP_CAP_NEXT = 8'hEC;

  // Field layout of the address/flag half-word inside the E4h dword
  localparam int PDP_ADDR_LSB = 16;
  localparam int PDP_ADDR_W = 9;
  localparam int PDP_FLAG_BIT = 31;
  localparam int PDP_ADDR_HI_BIT = 24;

  // Byte enables of the two upper lanes
  localparam int PDP_BE_ADDR_LO = 2;
  localparam int PDP_BE_ADDR_HI = 3;

  // Product data starts at this physical ROM byte address
  localparam logic [9:0] PDP_ROM_BASE = 10'h080;
  localparam logic [8:0] PDP_ADDR_MAX = 9'h17F;

  // Index of the last byte of every four-byte access
  localparam logic [1:0] PDP_LAST_BYTE = 2'h3;

  localparam logic [8:0] PDP_ADDR_RST = 9'h000;
  localparam logic PDP_FLAG_RST = 1'b0;
  localparam logic [31:0] PDP_DATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [3:0] be;
    logic [31:0] wdata;
  } pdp_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } pdp_cfg_rsp_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [9:0] addr;
    logic [7:0] wdata;
  } pdp_rom_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } pdp_rom_rsp_t;

  typedef enum logic [2:0] {
    PDP_E_IDLE = 3'b001,
    PDP_E_ISSUE = 3'b010,
    PDP_E_WAIT = 3'b100
  } pdp_eng_st_t;

endpackage

// [src/pdp_rom_engine.sv]
/*
  Four-byte sequencer that moves one product-data word to or from the
  serial ROM, one byte at a time over a simple req/ack byte port.
  Assumes the ROM byte controller shares ref_clk and answers each
  request with a one-cycle ack.
*/
`timescale 1ns/1ps
module pdp_rom_engine
  import pdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic start_we,
  input wire logic [8:0] start_addr,
  input wire logic [31:0] start_wdata,
  output logic done,
  output logic done_we,
  output logic [31:0] rdata,
  output pdp_rom_req_t rom_req,
  input wire pdp_rom_rsp_t rom_rsp
);

  typedef struct packed {
    pdp_eng_st_t st;
    logic we;
    logic [8:0] addr;
    logic [31:0] wdata;
    logic [1:0] idx;
    logic [31:0] rdata;
    logic done;
    pdp_rom_req_t rom;
  } pdp_eng_state_t;

  pdp_eng_state_t s;
  pdp_eng_state_t next_s;

  // Physical address; no alignment is forced on the start
  function automatic logic [9:0] rom_addr(input logic [8:0] a, input logic [1:0] i);
    rom_addr = PDP_ROM_BASE + {1'b0, a} + {8'h00, i};
  endfunction

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      PDP_E_IDLE: begin
        if (start) begin
          next_s.we = start_we;
          next_s.addr = start_addr;
          next_s.wdata = start_wdata;
          next_s.idx = 2'h0;
          next_s.st = PDP_E_ISSUE;
        end
      end
      PDP_E_ISSUE: begin
        next_s.rom.req = 1'b1;
        next_s.rom.we = s.we;
        next_s.rom.addr = rom_addr(s.addr, s.idx);
        next_s.rom.wdata = s.wdata[{s.idx, 3'b000} +: 8];
        next_s.st = PDP_E_WAIT;
      end
      PDP_E_WAIT: begin
        if (rom_rsp.ack) begin
          next_s.rom.req = 1'b0;
          if (!s.we) begin
            next_s.rdata[{s.idx, 3'b000} +: 8] = rom_rsp.rdata;
          end
          if (s.idx == PDP_LAST_BYTE) begin
            next_s.done = 1'b1;
            next_s.st = PDP_E_IDLE;
          end else begin
            next_s.idx = s.idx + 2'h1;
            next_s.st = PDP_E_ISSUE;
          end
        end
      end
      default: begin
        next_s.st = PDP_E_IDLE;
        next_s.rom.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= PDP_E_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign done_we = s.we;
  assign rdata = s.rdata;
  assign rom_req = s.rom;

endmodule

// [src/pdp_data_port.sv]
/*
  Product-data ROM access registers as seen from the primary and the
  secondary configuration interfaces: the address/flag half-word and
  the 32-bit data word, plus the sequencer that runs the ROM transfer.
  Assumes both configuration ports and the ROM byte controller run on
  ref_clk; configuration requests are one-cycle strobes.
*/
// Summary of operation
// - A 32-bit read/write data word holds the four bytes of the latest or pending ROM access.
// - Every ROM access moves exactly four bytes.
// - Byte lane 0 maps to the start address and lanes 1 to 3 to the next three addresses.
// - The start address may be any byte address and is never forced to dword alignment.
// - The 9-bit byte address, valid 000h to 17Fh, is added to base 080h to form the ROM address.
// - Writing 0 to the flag starts a four-byte read, and the flag goes to 1 when the data is in.
// - Writing 1 to the flag starts a four-byte write of the staged word, and the flag goes to 0 when done.
`timescale 1ns/1ps
module pdp_data_port
  import pdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pdp_cfg_req_t pri_req,
  output pdp_cfg_rsp_t pri_rsp,
  input wire pdp_cfg_req_t sec_req,
  output pdp_cfg_rsp_t sec_rsp,
  output pdp_rom_req_t rom_req,
  input wire pdp_rom_rsp_t rom_rsp,
  output logic busy
);

  typedef struct packed {
    logic [8:0] addr;
    logic flag;
    logic [31:0] data;
    logic start;
    logic busy;
    pdp_cfg_rsp_t [1:0] rsp;
  } pdp_port_state_t;

  pdp_port_state_t s;
  pdp_port_state_t next_s;

  logic eng_done;
  logic eng_done_we;
  logic [31:0] eng_rdata;
  pdp_cfg_req_t [1:0] req;

  assign req[0] = pri_req;
  assign req[1] = sec_req;

  function automatic logic dword_hit(input logic [7:0] off, input logic [7:0] reg_off);
    dword_hit = (off[7:2] == reg_off[7:2]);
  endfunction

  // Reserved bits 30:25 read as zero; unmapped offsets answer zero
  function automatic logic [31:0] readback(input logic [7:0] off, input logic [8:0] a,
                                           input logic f, input logic [31:0] d);
    readback = 32'h0000_0000;
    if (dword_hit(off, PDP_OFF_CAP_ADDR)) begin
      readback[PDP_FLAG_BIT] = f;
      readback[PDP_ADDR_LSB +: PDP_ADDR_W] = a;
      readback[15:8] = PDP_CAP_NEXT;
      readback[7:0] = PDP_CAP_ID;
    end else if (dword_hit(off, PDP_OFF_DATA)) begin
      readback = d;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    // Primary is applied first, so a same-cycle secondary write wins
    for (int i = 0; i < 2; i++) begin
      next_s.rsp[i].valid = req[i].valid;
      next_s.rsp[i].rdata = req[i].valid ? readback(req[i].offset, s.addr, s.flag, s.data) : s.rsp[i].rdata;
      if (req[i].valid && req[i].write) begin
        if (dword_hit(req[i].offset, PDP_OFF_CAP_ADDR)) begin
          if (req[i].be[PDP_BE_ADDR_LO]) begin
            next_s.addr[7:0] = req[i].wdata[PDP_ADDR_LSB +: 8];
          end
          if (req[i].be[PDP_BE_ADDR_HI]) begin
            next_s.addr[8] = req[i].wdata[PDP_ADDR_HI_BIT];
            next_s.flag = req[i].wdata[PDP_FLAG_BIT];
            // A start while busy is dropped by the sequencer, except in its done cycle, where it is taken while busy clears
            next_s.start = 1'b1;
          end
        end else if (dword_hit(req[i].offset, PDP_OFF_DATA)) begin
          next_s.data = merge(next_s.data, req[i].wdata, req[i].be);
        end
      end
    end
    if (s.start && !s.busy) begin
      next_s.busy = 1'b1;
    end
    // Completion overrides a same-cycle software write of the flag
    if (eng_done) begin
      next_s.busy = 1'b0;
      if (eng_done_we) begin
        next_s.flag = 1'b0;
      end else begin
        next_s.flag = 1'b1;
        next_s.data = eng_rdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.addr <= PDP_ADDR_RST;
      s.flag <= PDP_FLAG_RST;
      s.data <= PDP_DATA_RST;
    end else begin
      s <= next_s;
    end
  end

  pdp_rom_engine u_engine (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(s.start),
    .start_we(s.flag),
    .start_addr(s.addr),
    .start_wdata(s.data),
    .done(eng_done),
    .done_we(eng_done_we),
    .rdata(eng_rdata),
    .rom_req(rom_req),
    .rom_rsp(rom_rsp)
  );

  assign pri_rsp = s.rsp[0];
  assign sec_rsp = s.rsp[1];
  assign busy = s.busy;

endmodule

// [test/pdp_data_port_monitor.sv]
/*
  Port checker for the product-data port.
  Assumes one clock domain and the byte req/ack handshake of the ROM port.
*/
`timescale 1ns/1ps
module pdp_data_port_monitor
  import pdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pdp_cfg_req_t pri_req,
  input wire pdp_cfg_rsp_t pri_rsp,
  input wire pdp_cfg_req_t sec_req,
  input wire pdp_cfg_rsp_t sec_rsp,
  input wire pdp_rom_req_t rom_req,
  input wire pdp_rom_rsp_t rom_rsp,
  input wire logic busy
);
  // Lane counter and first address of the running transfer
  logic [1:0] n;
  logic [9:0] a0;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      n <= 2'h0;
      a0 <= 10'h000;
    end else if (rom_req.req && rom_rsp.ack) begin
      n <= n + 2'h1;
      if (n == 2'h0)
        a0 <= rom_req.addr;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    pri_req.valid && pri_req.write && pri_req.offset == PDP_OFF_CAP_ADDR && pri_req.be[3:2] == 2'b11 && !busy;
  endsequence
  sequence s_last;
    rom_req.req && rom_rsp.ack && n == 2'h3;
  endsequence
  a_pri_answer: assert property (pri_req.valid |=> pri_rsp.valid) else $error("primary answer missing");
  a_sec_answer: assert property (sec_req.valid |=> sec_rsp.valid) else $error("secondary answer missing");
  a_req_holds: assert property (rom_req.req && !rom_rsp.ack |=> rom_req.req && $stable(rom_req.addr))
    else $error("rom request dropped early");
  a_lane_addr: assert property (rom_req.req && n != 2'h0 |-> rom_req.addr == a0 + 10'(n))
    else $error("lane address wrong");
  a_start_addr: assert property (s_start |-> ##3 rom_req.req &&
    rom_req.addr == PDP_ROM_BASE + {1'b0, $past(pri_req.wdata[24:16], 3)}) else $error("start address wrong");
  a_four_bytes: assert property (s_last |=> !rom_req.req ##1 !busy) else $error("transfer not ended");
  a_no_idle: assert property (rom_req.req |-> busy) else $error("rom request while idle");
endmodule

// [test/pdp_rom_model.sv]
/*
  Behavioural serial ROM behind the byte port, 1024 bytes, byte i holds the low eight bits of i.
  Assumes ref_clk; slow stretches each ack by five cycles.
*/
`timescale 1ns/1ps
module pdp_rom_model
  import pdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire pdp_rom_req_t rom_req,
  output pdp_rom_rsp_t rom_rsp
);
  logic [7:0] mem [1024];
  logic [2:0] cnt;
  initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0];
  // Read data is only good with ack; otherwise it toggles
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 3'h0;
      rom_rsp <= '0;
    end else begin
      rom_rsp.ack <= 1'b0;
      rom_rsp.rdata <= ~rom_rsp.rdata;
      if (rom_req.req && !rom_rsp.ack) begin
        cnt <= cnt + 3'h1;
        if (cnt == (slow ? 3'h5 : 3'h0)) begin
          cnt <= 3'h0;
          rom_rsp.ack <= 1'b1;
          if (rom_req.we)
            mem[rom_req.addr] <= rom_req.wdata;
          else
            rom_rsp.rdata <= mem[rom_req.addr];
        end
      end
    end
  end
endmodule

// [test/pdp_data_port_tb.sv]
/*
  Self-checking bench: config accesses on both ports, ROM reads and writes.
  Assumes the ROM model above on the byte port.
*/
`timescale 1ns/1ps
module pdp_data_port_tb;
  import pdp_pkg::*;
  logic ref_clk = 0;
  logic arst_n = 0;
  logic slow = 0;
  logic busy;
  pdp_cfg_req_t pri_req = '0;
  pdp_cfg_req_t sec_req = '0;
  pdp_cfg_rsp_t pri_rsp;
  pdp_cfg_rsp_t sec_rsp;
  pdp_rom_req_t rom_req;
  pdp_rom_rsp_t rom_rsp;
  int err_total = 0;
  int tests_run = 0;
  int acks = 0;
  logic [31:0] rd;
  pdp_data_port pdp_data_port_i (.*);
  pdp_rom_model pdp_rom_model_i (.*);
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rom_rsp.ack === 1'b1) acks++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input bit s, input logic w, input logic [7:0] o, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk);
    if (s) sec_req = '{1'b1, w, o, be, d};
    else pri_req = '{1'b1, w, o, be, d};
    @(negedge ref_clk);
    pri_req.valid = 1'b0;
    sec_req.valid = 1'b0;
    chk({31'h0, s ? sec_rsp.valid : pri_rsp.valid}, 32'h1);
    rd = s ? sec_rsp.rdata : pri_rsp.rdata;
  endtask
  task automatic run(input bit s, input logic f, input logic [8:0] a);
    int a_was;
    a_was = acks;
    acc(s, 1'b1, PDP_OFF_CAP_ADDR, 4'hC, {f, 6'h0, a, 16'h0});
    for (int i = 0; i < 9 && busy !== 1'b1; i++) @(negedge ref_clk);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge ref_clk);
    chk(32'(acks - a_was), 32'h4);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) arst_n = 1'b1;
    acc(0, 0, PDP_OFF_CAP_ADDR, 4'hF, 0); chk(rd, 32'h0000_EC03);
    acc(1, 0, PDP_OFF_DATA, 4'hF, 0); chk(rd, 32'h0);
    acc(0, 0, 8'hF0, 4'hF, 0); chk(rd, 32'h0);
    $display("reset test ended");
    acc(1, 1, PDP_OFF_DATA, 4'hF, 32'hA1B2_C3D4);
    slow = 1'b1;
    run(1, 1, 9'h17F);
    acc(0, 0, PDP_OFF_CAP_ADDR, 4'hF, 0); chk(rd, 32'h017F_EC03);
    for (int i = 0; i < 4; i++) chk({24'h0, pdp_rom_model_i.mem[511 + i]}, 32'hA1B2_C3D4 >> (8 * i) & 32'hFF);
    $display("write test ended");
    slow = 1'b0;
    run(0, 0, 9'h001);
    acc(0, 0, PDP_OFF_CAP_ADDR, 4'hF, 0); chk(rd, 32'h8001_EC03);
    acc(0, 0, PDP_OFF_DATA, 4'hF, 0); chk(rd, 32'h8483_8281);
    acc(1, 1, PDP_OFF_DATA, 4'h1, 32'hFFFF_FFEE);
    acc(1, 0, PDP_OFF_DATA, 4'hF, 0); chk(rd, 32'h8483_82EE);
    run(0, 0, 9'h17F);
    acc(0, 0, PDP_OFF_DATA, 4'hF, 0); chk(rd, 32'hA1B2_C3D4);
    $display("read test ended");
    // Reset in the middle of a read must abort it and clear every register
    acc(0, 1, PDP_OFF_CAP_ADDR, 4'hC, {1'b0, 6'h0, 9'h010, 16'h0});
    repeat (4) @(negedge ref_clk);
    arst_n = 1'b0;
    @(negedge ref_clk);
    chk({30'h0, busy, rom_req.req}, 32'h0);
    arst_n = 1'b1;
    acc(0, 0, PDP_OFF_CAP_ADDR, 4'hF, 0); chk(rd, 32'h0000_EC03);
    acc(1, 0, PDP_OFF_DATA, 4'hF, 0); chk(rd, 32'h0);
    // Address byte alone must not start an access
    acc(0, 1, PDP_OFF_CAP_ADDR, 4'h4, 32'h0012_0000);
    repeat (3) @(negedge ref_clk);
    chk({31'h0, busy}, 32'h0);
    acc(1, 0, PDP_OFF_CAP_ADDR, 4'hF, 0); chk(rd, 32'h0012_EC03);
    $display("second reset test ended");
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    report_and_stop;
  end
endmodule
bind pdp_data_port pdp_data_port_monitor pdp_data_port_monitor_i (.*);
